// file: core/acc_pkg.sv
package acc_pkg;

    // -------------------------------------------------------------------------
    // Register map (byte addresses on APB)
    // -------------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h10;
    localparam logic [7:0] ADDR_IRQ = 8'h14;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int CTRL0_START_BIT = 7;
    localparam int CTRL0_BUSY_BIT = 6;
    localparam int CTRL0_ENABLE_BIT = 5;
    localparam int CTRL0_FORMAT_BIT = 4;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_ENABLE_BIT = 1;
    localparam int IRQ_GLOBAL_BIT = 2;

    // -------------------------------------------------------------------------
    // Reset values and codes
    // -------------------------------------------------------------------------
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_GROUND_LO = 3'h2;
    localparam logic [2:0] SRC_GROUND_HI = 3'h4;
    localparam logic [11:0] RESULT_FULL_SCALE = 12'hfff;

    // -------------------------------------------------------------------------
    // Conversion timing in converter clock periods
    // -------------------------------------------------------------------------
    localparam logic [4:0] SAMPLE_PERIODS = 5'h04;
    localparam logic [4:0] CONVERT_PERIODS = 5'h0c;
    localparam logic [4:0] TOTAL_PERIODS = 5'h10;

    typedef enum logic [1:0] {
        ACC_SRC_EXTERNAL,
        ACC_SRC_BANDGAP,
        ACC_SRC_GROUND
    } acc_source_type;

    typedef struct packed {
        logic [7:0] channel_onehot;
        logic bandgap_connect;
        logic ground_connect;
        logic sample;
        logic convert;
        logic powered;
    } acc_analog_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acc_apb_req_type;

endpackage

// file: core/acc_control.sv
`timescale 1ns/1ps

// Overview of operation
// R1: Source codes 000 or 101-111 route external channel 0-7 chosen by channel field.
// R2: External source with channel codes 1000-1111 connects nothing; input floats.
// R3: Source 001 connects bandgap; 010-100 connect analog ground, channel ignored.
// R4: Internal source selected disconnects every external channel automatically.
// R5: Pin assigned as analog input has all other functions disabled.
// R6: Pull-up on a pin assigned as analog input is disconnected.
// R7: Analog assignment overrides the pin's port direction setting.
// R8: Conversion is 4 sampling plus 12 converting clock periods, 16 total.
// R9: Start bit low-high-low; high holds converter reset, conversion starts on fall.
// R10: Busy flag high during conversion; result readable once it clears.
// R11: Conversion runs autonomously in hardware after start.
// R12: Clearing enable powers the converter core down.
// R13: Result is unsigned 12-bit, full scale FFF.
// R14: Software sets both interrupt enables before start if interrupts wanted.
// R15: Software selects a non-existent channel before choosing an internal source.
// R16: Software sets divider, enable, source, channel, reference, format, then starts.
// R17: Software assigns pin to analog function before selecting its channel.
// R18: Format 0 left-justifies result, format 1 right-justifies it.
// R19: Clock-select codes 001-111 divide system clock by 2 to 128; 000 reserved.
// R20: Completion sets interrupt flag and raises an interrupt signal.
// R21: Disabling the converter leaves both result registers unchanged.
// R22: Start during conversion aborts and restarts from sampling; result kept.
module acc_control (
    input wire logic clk,
    input wire logic rst,
    input wire acc_pkg::acc_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] core_data,
    output acc_pkg::acc_analog_type analog_ctrl,
    output logic [7:0] pin_analog_mode,
    output logic [7:0] pin_pullup_off,
    output logic [7:0] pin_dir_override,
    output logic irq
);
    import acc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESET,
        ST_SAMPLE,
        ST_CONVERT
    } acc_state_type;

    logic [7:0] ctrl0_q, ctrl0_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] pin_func_q, pin_func_d;
    logic [2:0] irq_q, irq_d;
    logic [11:0] result_q, result_d;
    acc_state_type state_q, state_d;
    logic [4:0] period_q, period_d;
    logic [6:0] div_q, div_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pslverr_q, irq_out_q;
    acc_analog_type analog_q, analog_d;

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    wire logic access = apb_req.psel && apb_req.penable && !pready_q;
    wire logic wr = access && apb_req.pwrite;
    wire logic wr_ctrl0 = wr && apb_req.paddr == ADDR_CTRL0;
    wire logic wr_ctrl1 = wr && apb_req.paddr == ADDR_CTRL1;
    wire logic wr_pin = wr && apb_req.paddr == ADDR_PIN_FUNC;
    wire logic wr_irq = wr && apb_req.paddr == ADDR_IRQ;
    wire logic mapped = apb_req.paddr == ADDR_CTRL0 || apb_req.paddr == ADDR_CTRL1
        || apb_req.paddr == ADDR_RES_HIGH || apb_req.paddr == ADDR_RES_LOW
        || apb_req.paddr == ADDR_PIN_FUNC || apb_req.paddr == ADDR_IRQ;

    // -------------------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------------------
    wire logic start_bit = ctrl0_q[CTRL0_START_BIT];
    wire logic enable = ctrl0_q[CTRL0_ENABLE_BIT];
    wire logic format = ctrl0_q[CTRL0_FORMAT_BIT];
    wire logic [3:0] channel_sel = ctrl0_q[3:0];
    wire logic [2:0] input_source_sel = ctrl1_q[7:5];
    wire logic [2:0] conv_clock_div_sel = ctrl1_q[2:0];
    wire logic busy = state_q != ST_IDLE && state_q != ST_RESET;

    // Start bit falling edge, seen as the write that clears a set start bit.
    wire logic start_fall = wr_ctrl0 && start_bit && !apb_req.pwdata[CTRL0_START_BIT];

    // Source decode.
    wire logic src_bandgap = input_source_sel == SRC_BANDGAP; // [R3]
    wire logic src_ground = input_source_sel >= SRC_GROUND_LO
        && input_source_sel <= SRC_GROUND_HI; // [R3]
    wire logic src_external = !src_bandgap && !src_ground; // [R1]

    // Converter clock tick; reserved code 000 gives no tick at all.
    wire logic [6:0] div_last = 7'((8'h02 << (conv_clock_div_sel - 3'h1)) - 8'h01); // [R19]
    wire logic div_valid = conv_clock_div_sel != 3'h0; // [R19]
    wire logic tick = div_valid && div_q == div_last;

    // Result placement in the two result registers.
    wire logic [7:0] res_high = format ? {4'h0, result_q[11:8]} : result_q[11:4]; // [R18]
    wire logic [7:0] res_low = format ? result_q[7:0] : {result_q[3:0], 4'h0}; // [R18]

    // Channel routing: one-hot only for existing channels with an external source.
    logic [7:0] chan_onehot;
    always_comb begin
        chan_onehot = 8'h00;
        if (src_external && !channel_sel[3]) begin // [R1] [R2] [R4]
            chan_onehot[channel_sel[2:0]] = 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    logic done;
    always_comb begin
        state_d = state_q;
        period_d = period_q;
        div_d = (tick || !busy) ? 7'h00 : div_q + 7'h01;
        result_d = result_q;
        done = 1'b0;
        if (!enable) begin
            state_d = ST_IDLE; // [R12] [R21]
        end else if (start_bit) begin
            state_d = ST_RESET; // [R9] [R22]
        end else if (start_fall || (state_q == ST_RESET)) begin
            state_d = ST_SAMPLE; // [R9]
            period_d = 5'h00;
            div_d = 7'h00;
        end else if (busy && tick) begin // [R11]
            period_d = period_q + 5'h01;
            if (period_q == SAMPLE_PERIODS - 5'h01) begin
                state_d = ST_CONVERT; // [R8]
            end
            if (period_q == TOTAL_PERIODS - 5'h01) begin
                state_d = ST_IDLE; // [R8] [R10]
                result_d = core_data; // [R13]
                done = 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        pin_func_d = pin_func_q;
        irq_d = irq_q;
        if (wr_ctrl0) begin
            ctrl0_d = apb_req.pwdata[7:0];
        end
        ctrl0_d[CTRL0_BUSY_BIT] = 1'b0;
        if (wr_ctrl1) begin
            ctrl1_d = apb_req.pwdata[7:0];
        end
        if (wr_pin) begin
            pin_func_d = apb_req.pwdata[7:0];
        end
        if (wr_irq) begin
            irq_d = apb_req.pwdata[2:0];
        end
        if (done) begin
            irq_d[IRQ_FLAG_BIT] = 1'b1; // [R20]
        end
    end

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (access && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                ADDR_CTRL0: prdata_d = {24'h000000, start_bit, busy, ctrl0_q[5:0]}; // [R10]
                ADDR_CTRL1: prdata_d = {24'h000000, ctrl1_q};
                ADDR_RES_HIGH: prdata_d = {24'h000000, res_high};
                ADDR_RES_LOW: prdata_d = {24'h000000, res_low};
                ADDR_PIN_FUNC: prdata_d = {24'h000000, pin_func_q};
                ADDR_IRQ: prdata_d = {29'h00000000, irq_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        analog_d.channel_onehot = chan_onehot & pin_func_q;
        analog_d.bandgap_connect = enable && src_bandgap; // [R3] [R4]
        analog_d.ground_connect = enable && src_ground; // [R3] [R4]
        analog_d.sample = state_d == ST_SAMPLE; // [R8]
        analog_d.convert = state_d == ST_CONVERT; // [R8]
        analog_d.powered = enable; // [R12]
    end

    // -------------------------------------------------------------------------
    // Flip-flops
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl0_q <= CTRL0_RESET;
            ctrl1_q <= CTRL1_RESET;
            pin_func_q <= PIN_FUNC_RESET;
            irq_q <= 3'h0;
            result_q <= 12'h000;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            pin_func_q <= pin_func_d;
            irq_q <= irq_d;
            result_q <= result_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            period_q <= 5'h00;
            div_q <= 7'h00;
        end else begin
            state_q <= state_d;
            period_q <= period_d;
            div_q <= div_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_out_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= access;
            pslverr_q <= access && !mapped;
            irq_out_q <= irq_d[IRQ_FLAG_BIT] && irq_d[IRQ_ENABLE_BIT]
                && irq_d[IRQ_GLOBAL_BIT]; // [R20]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_q <= '0;
            pin_analog_mode <= 8'h00;
            pin_pullup_off <= 8'h00;
            pin_dir_override <= 8'h00;
        end else begin
            analog_q <= analog_d;
            pin_analog_mode <= pin_func_d; // [R5]
            pin_pullup_off <= pin_func_d; // [R6]
            pin_dir_override <= pin_func_d; // [R7]
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_ctrl = analog_q;
    assign irq = irq_out_q;

endmodule

// file: sim/acc_properties.sv
`timescale 1ns/1ps
module acc_properties (
    input wire logic clk,
    input wire logic rst,
    input wire acc_pkg::acc_apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] core_data,
    input wire acc_pkg::acc_analog_type analog_ctrl,
    input wire logic [7:0] pin_analog_mode,
    input wire logic [7:0] pin_pullup_off,
    input wire logic [7:0] pin_dir_override,
    input wire logic irq
);
    import acc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_wait: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pullup_pin: assert property (pin_pullup_off == pin_analog_mode)
        else $error("pull-up not cut on analog pin");
    a_dir_pin: assert property (pin_dir_override == pin_analog_mode)
        else $error("direction not overridden on analog pin");
    a_ext_cut: assert property (analog_ctrl.bandgap_connect || analog_ctrl.ground_connect
        |-> analog_ctrl.channel_onehot == 8'h00)
        else $error("external channel joined to internal source");
    a_one_channel: assert property ($onehot0(analog_ctrl.channel_onehot))
        else $error("several channels connected");
    a_pin_gate: assert property ((analog_ctrl.channel_onehot & ~pin_analog_mode) == 8'h00)
        else $error("channel connected to non-analog pin");
    a_sample_first: assert property ($rose(analog_ctrl.convert) |-> $past(analog_ctrl.sample))
        else $error("conversion without preceding sampling");
    a_phase_excl: assert property (!(analog_ctrl.sample && analog_ctrl.convert))
        else $error("sample and convert together");
    c_done: cover property ($fell(analog_ctrl.convert));
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
    c_bandgap: cover property (analog_ctrl.bandgap_connect);
endmodule

bind acc_control acc_properties u_props (.clk(clk), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_data(core_data),
    .analog_ctrl(analog_ctrl), .pin_analog_mode(pin_analog_mode),
    .pin_pullup_off(pin_pullup_off), .pin_dir_override(pin_dir_override), .irq(irq));

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import acc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    acc_apb_req_type req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [11:0] core_data = 12'h000;
    acc_analog_type actl;
    logic [7:0] amode;
    logic [7:0] pull;
    logic [7:0] dir;
    logic [31:0] rd;
    logic err;
    logic [11:0] old_res = 12'h000;
    int error_cnt = 0;
    int num_checks = 0;
    int s_run = 0;
    int c_run = 0;
    int s_len = 0;
    int c_len = 0;
    always #5 clk = ~clk;
    acc_control uut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_data(core_data), .analog_ctrl(actl),
        .pin_analog_mode(amode), .pin_pullup_off(pull), .pin_dir_override(dir), .irq(irq));
    // Lengths of the last sampling and converting phases, in system clocks.
    always @(posedge clk) begin
        s_run = actl.sample ? s_run + 1 : 0;
        c_run = actl.convert ? c_run + 1 : 0;
        if (s_run != 0) s_len = s_run;
        if (c_run != 0) c_len = c_run;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        req <= '0;
        if (n >= 20) error_cnt++;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic conv(input logic [2:0] dv, input logic fmt, input logic [11:0] d,
        input logic ab);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [31:0] c0;
        int n;
        n = 0;
        c0 = {24'h0, 3'b001, fmt, 4'h0};
        hi = fmt ? {4'h0, d[11:8]} : d[11:4];
        lo = fmt ? d[7:0] : {d[3:0], 4'h0};
        core_data <= d;
        apb(1'b1, ADDR_CTRL1, {29'h0, dv});
        apb(1'b1, ADDR_CTRL0, c0 | 32'h80);
        apb(1'b1, ADDR_CTRL0, c0);
        rdchk("busy", ADDR_CTRL0, c0 | 32'h40);
        if (ab) begin
            apb(1'b1, ADDR_CTRL0, c0 | 32'h80);
            rdchk("kept_hi", ADDR_RES_HIGH,
                fmt ? {28'h0, old_res[11:8]} : {24'h0, old_res[11:4]});
            apb(1'b1, ADDR_CTRL0, c0);
        end
        rd = 32'h40;
        while (rd[CTRL0_BUSY_BIT] !== 1'b0 && n < 60) begin
            apb(1'b0, ADDR_CTRL0, 32'h0);
            n++;
        end
        if (n >= 60) error_cnt++;
        chk("sample_len", 32'd4 << dv, s_len);
        chk("convert_len", 32'd12 << dv, c_len);
        rdchk("res_hi", ADDR_RES_HIGH, {24'h0, hi});
        rdchk("res_lo", ADDR_RES_LOW, {24'h0, lo});
        old_res = d;
        $display("test conversion div %0d done", dv);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("ctrl0_rst", ADDR_CTRL0, 32'h0);
        rdchk("ctrl1_rst", ADDR_CTRL1, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, ADDR_PIN_FUNC, 32'h03);
        chk("pins", 32'h030303, {8'h0, amode, pull, dir});
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, ADDR_CTRL0, (s >= 1 && s <= 5) ? 32'h28 : 32'h21);
            apb(1'b1, ADDR_CTRL1, s << 5);
            @(posedge clk);
            chk("route", {21'h0, (s == 0 || s > 5) ? 8'h02 : 8'h00, s == 1, s > 1 && s < 5,
                1'b1}, {21'h0, actl.channel_onehot, actl.bandgap_connect,
                actl.ground_connect, actl.powered});
        end
        $display("test routing done");
        conv(3'd1, 1'b0, 12'habc, 1'b0);
        rdchk("flag", ADDR_IRQ, 32'h1);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_IRQ, 32'h7);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ, 32'h6);
        chk("irq_clr", 32'h0, {31'h0, irq});
        conv(3'd2, 1'b1, 12'h5e7, 1'b1);
        apb(1'b1, ADDR_CTRL0, 32'h0);
        @(posedge clk);
        chk("power", 32'h0, {31'h0, actl.powered});
        rdchk("keep_lo", ADDR_RES_LOW, {24'h0, old_res[3:0], 4'h0});
        $display("test power down done");
        give_verdict;
    end
endmodule
